// *** hw/sts_regs.sv ***
// supply and thermal status register bank with its serial frame port
`include "sts_cfg.svh"

// Operation
// - one frame is sixteen bits, two bytes
// - first byte: 7-bit address, mode bit
// - data bits occupy frame bits 8-15
// - mode bit zero: read, flags untouched
// - mode bit one: clear the flags reported in the frame
// - flags fall only by clear command, reset or restart
// - reserved bits always read zero
// - supply register B flag layout at 0x40
// - supply register A flag layout at 0x41
// - power-on gives 0x80, soft reset 0x00
// - sleep with rail off: no rail flags except the prewarning
// - main undervoltage update gated by mode
// - short flag after 4ms below threshold
// - fourth consecutive undervoltage sets fail-safe flag
// - thermal register layout at 0x42
// - level-two shutdown sets flag, requests fail-safe
// - shutdown flags stay until host clears
// - thermal reset zero, restart keeps low bits
module sts_regs #(
  parameter int UV_LONG_CYCLES = `STS_UV_LONG_CYCLES
) (
  // system clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial link, its clock and pins
  input wire logic sclk,
  input wire logic csn_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // device state
  input wire sts_pkg::sts_mode_t mode,
  input wire logic main_rail_on,
  input wire logic reset_output_released,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic uv_streak_clear,
  // fault conditions
  input wire sts_pkg::sts_fault_t fault,
  // results
  output logic failsafe_req,
  output sts_pkg::sts_regs_t regs
);

  localparam int CNT_W = $clog2(UV_LONG_CYCLES + 2);

  initial begin
    if (UV_LONG_CYCLES < 1) begin
      $error("sts_regs: UV_LONG_CYCLES must be at least one");
    end
    // the bit counter and the byte decode assume two equal bytes
    if (`STS_FRAME_BITS != 2 * `STS_HEAD_BITS) begin
      $error("sts_regs: frame must be two bytes");
    end
    // a restart may only keep bits that exist
    if ((`STS_KEEP_SUPPLY_B & ~`STS_MASK_SUPPLY_B) != 8'h00) begin
      $error("sts_regs: supply B keep mask outside implemented bits");
    end
    if ((`STS_KEEP_THERMAL & ~`STS_MASK_THERMAL) != 8'h00) begin
      $error("sts_regs: thermal keep mask outside implemented bits");
    end
    if (`STS_UV_STREAK_LIMIT == 3'h0) begin
      $error("sts_regs: undervoltage streak limit must be non-zero");
    end
  end

  // ---------------- link domain ----------------

  logic [4:0] bit_cnt;
  logic [7:0] head;
  logic [7:0] tx_byte;
  logic [15:0] cmd;
  logic done_tgl;

  // frame shadow, written only while the link is idle
  sts_pkg::sts_regs_t shadow;

  // address decode against the frozen shadow
  always_comb begin
    case (head[6:0])
      `STS_ADDR_SUPPLY_B: tx_byte = shadow.supply_fail_status_b;
      `STS_ADDR_SUPPLY_A: tx_byte = shadow.supply_fail_status_a;
      `STS_ADDR_THERMAL: tx_byte = shadow.thermal_status;
      default: tx_byte = 8'h00;
    endcase
  end

  // chip select clears the position so a broken frame never leaks into the next
  always_ff @(posedge sclk or posedge csn_n) begin
    if (csn_n) begin
      bit_cnt <= 5'h00;
    end else if (bit_cnt != `STS_FRAME_BITS) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge sclk or posedge csn_n) begin
    if (csn_n) begin
      head <= 8'h00;
    end else if (bit_cnt < `STS_HEAD_BITS) begin
      head[bit_cnt[2:0]] <= mosi;
    end
  end

  // the reported byte travels with the command, so the clear removes
  // exactly what the host has seen
  // cmd only moves at the sixteenth edge; frames are spaced so that it
  // holds still until the clk side has seen the toggle twice, which makes
  // the whole word safe to read without its own synchroniser
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      cmd <= 16'h0000;
      done_tgl <= 1'b0;
    end else if (!csn_n && bit_cnt == `STS_FRAME_BITS - 5'h01) begin
      cmd <= {tx_byte, head};
      done_tgl <= ~done_tgl;
    end
  end

  // first byte answers zero, second byte carries the register
  // launched on the falling edge so the host has half a period of setup
  always_ff @(negedge sclk or posedge csn_n) begin
    if (csn_n) begin
      miso <= 1'b0;
    end else if (bit_cnt >= `STS_HEAD_BITS && bit_cnt < `STS_FRAME_BITS) begin
      miso <= tx_byte[bit_cnt[2:0]];
    end else begin
      miso <= 1'b0;
    end
  end

  assign miso_oe = ~csn_n;

  // ---------------- crossing into clk ----------------

  logic [1:0] csn_sync;
  logic [2:0] done_sync;
  logic cmd_strobe;
  logic link_idle;

  // chip select and the done toggle pass two flops before use; the strobe
  // compares the second and third stage of the done chain to find the edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      csn_sync <= 2'h3;
      done_sync <= 3'h0;
    end else begin
      csn_sync <= {csn_sync[0], csn_n};
      done_sync <= {done_sync[1:0], done_tgl};
    end
  end

  assign link_idle = csn_sync[1];
  assign cmd_strobe = done_sync[2] ^ done_sync[1];

  // the link reads the shadow mid-frame; it only moves while chip select
  // is seen high, so it is steady long before the eighth edge needs it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      shadow <= '0;
    end else if (link_idle) begin
      shadow <= regs;
    end
  end

  // ---------------- clear decode ----------------

  logic [7:0] clr_b;
  logic [7:0] clr_a;
  logic [7:0] clr_t;

  always_comb begin
    clr_b = 8'h00;
    clr_a = 8'h00;
    clr_t = 8'h00;
    if (cmd_strobe && cmd[`STS_MODE_BIT]) begin
      case (cmd[6:0])
        `STS_ADDR_SUPPLY_B: clr_b = cmd[15:8];
        `STS_ADDR_SUPPLY_A: clr_a = cmd[15:8];
        `STS_ADDR_THERMAL: clr_t = cmd[15:8];
        default: clr_b = 8'h00;
      endcase
    end
  end
  // a read command leaves the masks at zero

  // ---------------- main rail supervision ----------------

  logic [CNT_W-1:0] uv_cnt;
  logic uv_long;
  logic uv_prev;
  logic [2:0] uv_streak;
  logic ro_seen;
  logic rail_quiet;
  logic uv_allow;
  logic uv_rise;
  logic streak_hit;

  // sleep with the rail off: its comparators are meaningless
  assign rail_quiet = (mode == sts_pkg::STS_MODE_SLEEP) && !main_rail_on;

  // the counter stops one past the limit, so a long short never wraps
  // and the short flag keeps being raised while it lasts
  always_ff @(posedge clk) begin
    if (!resetn) begin
      uv_cnt <= '0;
    end else if (!fault.main_rail_undervoltage || !main_rail_on) begin
      uv_cnt <= '0;
    end else if (!uv_long) begin
      uv_cnt <= uv_cnt + CNT_W'(1);
    end
  end

  // strictly longer than the limit
  assign uv_long = uv_cnt > CNT_W'(UV_LONG_CYCLES);

  always_ff @(posedge clk) begin
    if (!resetn || soft_reset) begin
      ro_seen <= 1'b0;
    end else if (mode == sts_pkg::STS_MODE_INIT && reset_output_released) begin
      ro_seen <= 1'b1;
    end
  end

  always_comb begin
    case (mode)
      sts_pkg::STS_MODE_NORMAL: uv_allow = 1'b1;
      sts_pkg::STS_MODE_STOP: uv_allow = 1'b1;
      sts_pkg::STS_MODE_INIT: uv_allow = ro_seen;
      sts_pkg::STS_MODE_RESTART: uv_allow = 1'b0;
      default: uv_allow = 1'b0;
    endcase
    // a short overrides the mode gate
    uv_allow = (uv_allow || uv_long) && !rail_quiet;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      uv_prev <= 1'b0;
    end else begin
      uv_prev <= fault.main_rail_undervoltage && main_rail_on;
    end
  end

  assign uv_rise = fault.main_rail_undervoltage && main_rail_on && !uv_prev;
  assign streak_hit = uv_rise && (uv_streak == `STS_UV_STREAK_LIMIT - 3'h1);

  // counts rising undervoltage events; the owner of the mode logic breaks
  // the streak through uv_streak_clear once the rail has recovered
  always_ff @(posedge clk) begin
    if (!resetn || soft_reset || uv_streak_clear || streak_hit) begin
      uv_streak <= 3'h0;
    end else if (uv_rise) begin
      uv_streak <= uv_streak + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      failsafe_req <= 1'b0;
    end else begin
      failsafe_req <= streak_hit || fault.thermal_shutdown_level_two;
    end
  end

  // ---------------- set vectors ----------------

  logic [7:0] set_b;
  logic [7:0] set_a;
  logic [7:0] set_t;

  always_comb begin
    set_b = 8'h00;
    set_b[`STS_B_BATT_UV] = fault.battery_supply_undervoltage;
    set_b[`STS_B_EXT_OC] = fault.ext_regulator_overcurrent;
    set_b[`STS_B_EXT_UV] = fault.ext_regulator_undervoltage;
    set_b[`STS_B_EXT_OT] = fault.ext_regulator_overtemp;
    set_b[`STS_B_MAIN_OV] = fault.main_rail_overvoltage && !rail_quiet;
    set_b[`STS_B_MAIN_WARN] = fault.main_rail_uv_prewarning;
    set_b = set_b & `STS_MASK_SUPPLY_B;
  end

  always_comb begin
    set_a = 8'h00;
    set_a[`STS_A_HS_UV] = fault.highside_supply_undervoltage;
    set_a[`STS_A_HS_OV] = fault.highside_supply_overvoltage;
    set_a[`STS_A_AUX_OT] = fault.aux_rail_overtemp;
    set_a[`STS_A_AUX_UV] = fault.aux_rail_undervoltage;
    set_a[`STS_A_MAIN_SC] = uv_long && !rail_quiet;
    set_a[`STS_A_MAIN_UV_FS] = streak_hit;
    set_a[`STS_A_MAIN_UV] = fault.main_rail_undervoltage && uv_allow;
    set_a = set_a & `STS_MASK_SUPPLY_A;
  end

  always_comb begin
    set_t = 8'h00;
    set_t[`STS_T_THERMAL_SHUTDOWN_LEVEL_TWO] = fault.thermal_shutdown_level_two;
    set_t[`STS_T_THERMAL_SHUTDOWN_LEVEL_ONE] = fault.thermal_shutdown_level_one;
    set_t[`STS_T_TPW] = fault.thermal_prewarning;
    set_t = set_t & `STS_MASK_THERMAL;
  end

  // ---------------- flag registers ----------------
  // flags only fall through a clear command, a reset or a restart; a set in the
  // clear cycle is applied after the clear and so survives

  always_ff @(posedge clk) begin
    if (!resetn || soft_reset) begin
      regs.supply_fail_status_b <= `STS_POR_SUPPLY_B;
    end else if (restart) begin
      // an event arriving with the restart still lands
      regs.supply_fail_status_b <= (regs.supply_fail_status_b & `STS_KEEP_SUPPLY_B) | set_b;
    end else begin
      regs.supply_fail_status_b <= ((regs.supply_fail_status_b & ~clr_b) | set_b)
        & `STS_MASK_SUPPLY_B;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      regs.supply_fail_status_a <= `STS_POR_SUPPLY_A;
    end else if (soft_reset) begin
      regs.supply_fail_status_a <= `STS_SOFT_SUPPLY_A;
    end else begin
      regs.supply_fail_status_a <= (regs.supply_fail_status_a & ~clr_a) | set_a;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || soft_reset) begin
      regs.thermal_status <= `STS_POR_THERMAL;
    end else if (restart) begin
      // an event arriving with the restart still lands
      regs.thermal_status <= (regs.thermal_status & `STS_KEEP_THERMAL) | set_t;
    end else begin
      // conditions going away do not touch the shutdown bits
      regs.thermal_status <= ((regs.thermal_status & ~clr_t) | set_t)
        & `STS_MASK_THERMAL;
    end
  end

endmodule // sts_regs

// *** hw/sts_cfg.svh ***
// constants of the supply and thermal status register bank
`ifndef STS_CFG_SVH
`define STS_CFG_SVH

// register addresses, 7-bit
`define STS_ADDR_SUPPLY_B 7'h40
`define STS_ADDR_SUPPLY_A 7'h41
`define STS_ADDR_THERMAL 7'h42

// frame layout
`define STS_FRAME_BITS 5'h10
`define STS_HEAD_BITS 5'h08
`define STS_MODE_BIT 7

// implemented flag bits per register
`define STS_MASK_SUPPLY_B 8'h5F
`define STS_MASK_SUPPLY_A 8'hFF
`define STS_MASK_THERMAL 8'h07

// reset values
`define STS_POR_SUPPLY_B 8'h00
`define STS_POR_SUPPLY_A 8'h80
`define STS_SOFT_SUPPLY_A 8'h00
`define STS_POR_THERMAL 8'h00
// bits kept through a restart
`define STS_KEEP_SUPPLY_B 8'h5D
`define STS_KEEP_THERMAL 8'h07

// field positions
`define STS_B_BATT_UV 6
`define STS_B_EXT_OC 4
`define STS_B_EXT_UV 3
`define STS_B_EXT_OT 2
`define STS_B_MAIN_OV 1
`define STS_B_MAIN_WARN 0
`define STS_A_POR 7
`define STS_A_HS_UV 6
`define STS_A_HS_OV 5
`define STS_A_AUX_OT 4
`define STS_A_AUX_UV 3
`define STS_A_MAIN_SC 2
`define STS_A_MAIN_UV_FS 1
`define STS_A_MAIN_UV 0
`define STS_T_THERMAL_SHUTDOWN_LEVEL_TWO 2
`define STS_T_THERMAL_SHUTDOWN_LEVEL_ONE 1
`define STS_T_TPW 0

// timing
`define STS_CLK_MHZ 200
`define STS_UV_LONG_US 4000
`define STS_UV_LONG_CYCLES (`STS_UV_LONG_US * `STS_CLK_MHZ)
`define STS_UV_STREAK_LIMIT 3'h4

`endif

// *** hw/sts_pkg.sv ***
// types shared by the status register bank
package sts_pkg;

  typedef enum logic [2:0] {
    STS_MODE_INIT,
    STS_MODE_NORMAL,
    STS_MODE_STOP,
    STS_MODE_SLEEP,
    STS_MODE_RESTART,
    STS_MODE_FAILSAFE
  } sts_mode_t;

  // fault conditions from the supervisors, high while present
  typedef struct packed {
    logic battery_supply_undervoltage;
    logic ext_regulator_overcurrent;
    logic ext_regulator_undervoltage;
    logic ext_regulator_overtemp;
    logic main_rail_overvoltage;
    logic main_rail_uv_prewarning;
    logic highside_supply_undervoltage;
    logic highside_supply_overvoltage;
    logic aux_rail_overtemp;
    logic aux_rail_undervoltage;
    logic main_rail_undervoltage;
    logic thermal_shutdown_level_two;
    logic thermal_shutdown_level_one;
    logic thermal_prewarning;
  } sts_fault_t;

  typedef struct packed {
    logic [7:0] supply_fail_status_b;
    logic [7:0] supply_fail_status_a;
    logic [7:0] thermal_status;
  } sts_regs_t;

endpackage

// *** dv/sts_regs_properties.sv ***
// port assertions of the status register bank
module sts_regs_props (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link pins
  input wire logic csn_n,
  input wire logic miso,
  input wire logic miso_oe,
  // device state
  input wire sts_pkg::sts_mode_t mode,
  input wire logic main_rail_on,
  input wire logic soft_reset,
  input wire logic restart,
  input wire sts_pkg::sts_fault_t fault,
  input wire logic failsafe_req,
  // registers
  input wire sts_pkg::sts_regs_t regs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_oe_follows_cs: assert property (miso_oe == !csn_n) else $error("miso enable wrong");
  a_miso_idle_low: assert property (csn_n |-> !miso) else $error("miso not low when idle");
  a_por_value: assert property ($rose(resetn) |-> regs == 24'h008000) else $error("reset value wrong");
  a_soft_clears_all: assert property (soft_reset && fault == '0 |=> regs == '0)
    else $error("soft reset left flags");
  a_reserved_zero: assert property ((regs.supply_fail_status_b & 8'hA0) == '0
    && (regs.thermal_status & 8'hF8) == '0) else $error("reserved bit set");
  a_prewarn_sets: assert property (fault.thermal_prewarning && !soft_reset |=> regs.thermal_status[0])
    else $error("prewarning flag not set");
  a_restart_keeps: assert property (restart && !soft_reset && fault == '0 |=>
    regs.thermal_status == ($past(regs.thermal_status) & 8'h07)
    && regs.supply_fail_status_b == ($past(regs.supply_fail_status_b) & 8'h5D)) else $error("restart value wrong");
  a_sleep_no_rail: assert property (mode == sts_pkg::STS_MODE_SLEEP && !main_rail_on |=>
    !$rose(regs.supply_fail_status_b[1]) && !$rose(regs.supply_fail_status_a[2])) else $error("rail flag in sleep");
  // clears land shortly after a frame, so only long idle stretches are watched
  a_flags_sticky: assert property (csn_n [*8] ##0 !soft_reset && !restart |=>
    ($past(regs) & ~regs) == '0) else $error("flag dropped by itself");
  a_thermal_shutdown_level_two_failsafe: assert property (fault.thermal_shutdown_level_two && !soft_reset |=> failsafe_req
    && regs.thermal_status[2]) else $error("level-two shutdown not latched");
endmodule // sts_regs_props

bind sts_regs sts_regs_props i_sts_regs_props (.clk, .resetn, .csn_n, .miso, .miso_oe, .mode,
  .main_rail_on, .soft_reset, .restart, .fault, .failsafe_req, .regs);

// *** dv/sts_host.sv ***
// host side model driving serial frames
module sts_host (
  // link pins
  output logic sclk,
  output logic csn_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // link clock stands low outside frames
  initial begin
    sclk = 0;
    csn_n = 1;
    mosi = 0;
  end
  task automatic xfer(input logic [7:0] h, output logic [7:0] q);
    // step off the system clock edge so the link runs out of phase
    #1 csn_n = 0;
    #20;
    for (int r = 1; r <= 16; r++) begin
      mosi = r <= 8 ? h[r-1] : ~mosi;
      #15 sclk = 1;
      if (r > 8) q[r-9] = miso;
      #15 sclk = 0;
    end
    #15 csn_n = 1;
    // released line shows no stale value
    mosi = ~mosi;
    #30;
  endtask
endmodule // sts_host

// *** dv/tb_supply_thermal_status_regs.sv ***
// self-checking bench of the status register bank
module tb_supply_thermal_status_regs;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
  logic clk = 0, resetn = 0, soft_reset = 0, restart = 0, uv_streak_clear = 0;
  logic main_rail_on = 1, reset_output_released = 0, failsafe_req, miso, miso_oe, sclk, csn_n, mosi;
  sts_pkg::sts_mode_t mode = sts_pkg::STS_MODE_INIT;
  sts_pkg::sts_fault_t fault = '0;
  sts_pkg::sts_regs_t regs;
  int n_errors = 0, n_compared = 0, cyc = 0, n_fs = 0;
  logic [7:0] d;
  // register image per fault input, first struct member first
  localparam logic [23:0] EXP [14] = '{24'h400000, 24'h100000, 24'h080000, 24'h040000, 24'h020000,
    24'h010000, 24'h004000, 24'h002000, 24'h001000, 24'h000800, 24'h000100, 24'h000004, 24'h000002, 24'h000001};

  sts_regs #(.UV_LONG_CYCLES(20)) i_sts_regs (.clk, .resetn, .sclk, .csn_n, .mosi, .miso, .miso_oe, .mode,
    .main_rail_on, .reset_output_released, .soft_reset, .restart, .uv_streak_clear, .fault, .failsafe_req, .regs);
  sts_host i_sts_host (.sclk, .csn_n, .mosi, .miso);

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (failsafe_req === 1'b1) n_fs++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input sts_pkg::sts_fault_t f);
    @(posedge clk) fault <= f;
    @(posedge clk) fault <= '0;
    step(2);
  endtask
  task automatic srst();
    @(posedge clk) {soft_reset, uv_streak_clear} <= 2'b11;
    @(posedge clk) {soft_reset, uv_streak_clear} <= 2'b00;
    step(1);
  endtask
  task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] e);
    i_sts_host.xfer({c, a}, d);
    `CHK(d, e)
    step(6);
  endtask

  task automatic t_por();
    `CHK(regs, 24'h008000)
    rd(7'h40, 0, 8'h00);
    rd(7'h41, 0, 8'h80);
    rd(7'h42, 0, 8'h00);
    rd(7'h43, 1, 8'h00);
    `CHK(regs, 24'h008000)
  endtask
  task automatic t_map();
    for (int i = 0; i < 14; i++) begin
      srst();
      pulse(14'h2000 >> i);
      `CHK(regs, EXP[i])
    end
    `CHK(n_fs, 1)
  endtask
  task automatic t_clear();
    pulse('1);
    step(40);
    `CHK(regs, 24'h5F7907)
    rd(7'h41, 1, 8'h79);
    `CHK(regs, 24'h5F0007)
    rd(7'h40, 0, 8'h5F);
    rd(7'h42, 1, 8'h07);
    rd(7'h42, 0, 8'h00);
    pulse('1);
    @(posedge clk) restart <= 1;
    @(posedge clk) restart <= 0;
    step(1);
    `CHK(regs, 24'h5D7907)
    `CHK(n_fs, 3)
  endtask
  task automatic t_uv();
    sts_pkg::sts_fault_t f;
    f = '0;
    f.main_rail_undervoltage = 1;
    f.main_rail_overvoltage = 1;
    // init before and after release, normal, stop, sleep with rail off, restart
    for (int i = 0; i < 6; i++) begin
      srst();
      @(posedge clk) begin
        mode <= i == 5 ? sts_pkg::STS_MODE_INIT : sts_pkg::sts_mode_t'(i);
        main_rail_on <= i != 3;
        reset_output_released <= i == 5;
      end
      pulse(f);
      `CHK(regs.supply_fail_status_a[0], 1'(6'b100110 >> i))
      `CHK(regs.supply_fail_status_b[1], 1'(i != 3))
    end
    f.main_rail_overvoltage = 0;
    srst();
    @(posedge clk) mode <= sts_pkg::STS_MODE_NORMAL;
    @(posedge clk) fault <= f;
    step(30);
    @(posedge clk) fault <= '0;
    step(2);
    `CHK(regs.supply_fail_status_a, 8'h05)
    repeat (3) pulse(f);
    `CHK(regs.supply_fail_status_a, 8'h07)
    `CHK(n_fs, 4)
  endtask

  initial begin
    step(12);
    resetn <= 1;
    step(3);
    t_por();
    @(posedge clk) mode <= sts_pkg::STS_MODE_NORMAL;
    t_map();
    t_clear();
    t_uv();
    close_out();
  end
endmodule // tb_supply_thermal_status_regs
